// >>> logic/crf_pkg.sv
// Package for the CPU core register file: widths, reset values, modes, carriers.
// Assumes a single clock domain and a synchronous active-high reset.
package crf_pkg;

    localparam int CRF_DW = 8;
    localparam int CRF_AW = 16;
    localparam logic [7:0] CRF_BYTE_ZERO = 8'h00;
    localparam logic [7:0] CRF_STACK_HI_PAGE0 = 8'h00;
    localparam logic [7:0] CRF_STACK_HI_PAGE1 = 8'h01;
    localparam logic [7:0] CRF_SP_RESET = 8'hff;
    localparam logic [15:0] CRF_PC_RESET = 16'h0000;
    localparam logic [15:0] CRF_PC_STEP = 16'h0001;
    localparam logic [1:0] CRF_MODE_SINGLE = 2'h0;
    localparam logic [1:0] CRF_MODE_EXPAND = 2'h1;
    localparam logic [1:0] CRF_MODE_MICRO = 2'h2;
    localparam logic [1:0] CRF_MODE_NONE = 2'h3;
    localparam int CRF_MODE_LSB = 0;
    localparam int CRF_STACK_PAGE_BIT = 2;
    localparam logic [7:0] CRF_MODE_REG_RESET = 8'h00;

    typedef enum logic [1:0]
    {
        CRF_SEL_A,
        CRF_SEL_X,
        CRF_SEL_Y,
        CRF_SEL_SP
    } crf_sel_e;

    typedef enum logic [1:0]
    {
        CRF_IDX_NONE,
        CRF_IDX_X,
        CRF_IDX_Y
    } crf_idx_e;

    typedef struct packed
    {
        logic we;
        crf_sel_e sel;
        logic [7:0] data;
    } crf_wr_s;

    typedef struct packed
    {
        logic advance;
        logic load;
        logic [15:0] value;
    } crf_pc_s;

    typedef struct packed
    {
        logic push;
        logic pop;
    } crf_stk_s;

endpackage

// >>> logic/crf_addr_calc.sv
// Effective and stack address former for the CPU register file.
// Assumes operands and register values are stable in the cycle they are used.
`timescale 1ns/1ps
`default_nettype none
module crf_addr_calc
    import crf_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire crf_idx_e idx_sel,
    input wire logic [15:0] operand,
    input wire logic [7:0] x_val,
    input wire logic [7:0] y_val,
    input wire logic [7:0] sp_val,
    input wire logic stack_page,
    output logic [15:0] eff_addr_q,
    output logic [15:0] stack_addr_q
);

    logic [7:0] idx_val;

    always_comb
    begin
        case (idx_sel)
            CRF_IDX_X: idx_val = x_val;
            CRF_IDX_Y: idx_val = y_val;
            default: idx_val = CRF_BYTE_ZERO;
        endcase
    end

    // ========================================
    // Address registers
    // operand plus index
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            eff_addr_q <= CRF_PC_RESET;
        else
            eff_addr_q <= operand + {CRF_BYTE_ZERO, idx_val};
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            stack_addr_q <= {CRF_STACK_HI_PAGE0, CRF_SP_RESET};
        else
            stack_addr_q <= {stack_page ? CRF_STACK_HI_PAGE1 : CRF_STACK_HI_PAGE0, sp_val};
    end

    // indexed sum check
    // The sampled reset in both indexed antecedents keeps the last reset edge out.
    eff_sum_a: assert property (@(posedge clock) disable iff (sys_rst)
        !sys_rst && idx_sel == CRF_IDX_X |=> eff_addr_q == $past(operand) + {CRF_BYTE_ZERO, $past(x_val)})
        else $error("X indexed address wrong");

    eff_y_sum_a: assert property (@(posedge clock) disable iff (sys_rst)
        !sys_rst && idx_sel == CRF_IDX_Y |=> eff_addr_q == $past(operand) + {CRF_BYTE_ZERO, $past(y_val)})
        else $error("Y indexed address wrong");

    stack_page_a: assert property (@(posedge clock) disable iff (sys_rst)
        1'b1 |=> stack_addr_q[15:8] == ($past(stack_page) ? 8'h01 : 8'h00))
        else $error("Stack page byte wrong");

endmodule
`default_nettype wire

// >>> logic/crf_status_out.sv
// Bus status outputs: DMA activity and opcode fetch marker.
// Assumes the core and DMA engine give single-clock status levels.
`timescale 1ns/1ps
`default_nettype none
module crf_status_out
    import crf_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [1:0] proc_mode,
    input wire logic dma_busy,
    input wire logic fetch_cycle,
    output logic dma_activity_output_q,
    output logic opcode_fetch_marker_q,
    output logic status_valid_q
);

    logic mode_ext;

    assign mode_ext = (proc_mode == CRF_MODE_EXPAND) || (proc_mode == CRF_MODE_MICRO);

    // ========================================
    // Status registers
    // high during transfer
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            dma_activity_output_q <= 1'b0;
        else
            dma_activity_output_q <= dma_busy;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            opcode_fetch_marker_q <= 1'b0;
        else
            opcode_fetch_marker_q <= fetch_cycle;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            status_valid_q <= 1'b0;
        else
            status_valid_q <= mode_ext;
    end

    // DMA output follows transfer
    // The sampled reset in the DMA and fetch antecedents keeps the last reset edge out.
    dma_follow_a: assert property (@(posedge clock) disable iff (sys_rst)
        !sys_rst && dma_busy |=> dma_activity_output_q)
        else $error("DMA activity output low during transfer");

    fetch_mark_a: assert property (@(posedge clock) disable iff (sys_rst)
        !sys_rst && $rose(fetch_cycle) |=> $rose(opcode_fetch_marker_q))
        else $error("Fetch marker missed");

    valid_mode_a: assert property (@(posedge clock) disable iff (sys_rst)
        proc_mode == CRF_MODE_SINGLE |=> !status_valid_q)
        else $error("Status valid in single-chip mode");

endmodule
`default_nettype wire

// >>> logic/crf_core.sv
// Core register file: accumulator, index registers, stack pointer, program
// counter, first CPU mode register, address former and bus status outputs.
// Assumes the sequencer outside drives one-cycle control strobes.
`timescale 1ns/1ps
`default_nettype none
module crf_core
    import crf_pkg::*;
#(
    parameter int DW = CRF_DW
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire crf_wr_s reg_wr,
    input wire crf_stk_s stack_op,
    input wire crf_pc_s pc_ctl,
    input wire crf_idx_e idx_sel,
    input wire logic [15:0] operand,
    input wire logic mode_wr,
    input wire logic [7:0] mode_wdata,
    input wire logic dma_busy,
    input wire logic fetch_cycle,
    output logic [7:0] acc_q,
    output logic [7:0] x_q,
    output logic [7:0] y_q,
    output logic [7:0] sp_q,
    output logic [7:0] program_counter_high_q,
    output logic [7:0] program_counter_low_q,
    output logic [7:0] cpu_mode_register_first_q,
    output logic [15:0] eff_addr_q,
    output logic [15:0] stack_addr_q,
    output logic dma_activity_output_q,
    output logic opcode_fetch_marker_q,
    output logic status_valid_q
);

    logic [15:0] pc_d;
    logic [DW-1:0] sp_d;
    logic [1:0] mode_field;

    // ========================================
    // Data registers
    // accumulator write
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            acc_q <= CRF_BYTE_ZERO;
        else if (reg_wr.we && reg_wr.sel == CRF_SEL_A)
            acc_q <= reg_wr.data;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            x_q <= CRF_BYTE_ZERO;
        else if (reg_wr.we && reg_wr.sel == CRF_SEL_X)
            x_q <= reg_wr.data;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            y_q <= CRF_BYTE_ZERO;
        else if (reg_wr.we && reg_wr.sel == CRF_SEL_Y)
            y_q <= reg_wr.data;
    end

    // ========================================
    // Stack pointer
    // A direct write beats push or pop; the stack grows downward, so the
    // pointer always names the next free save slot.
    always_comb
    begin
        sp_d = sp_q;
        if (reg_wr.we && reg_wr.sel == CRF_SEL_SP)
            sp_d = reg_wr.data;
        else if (stack_op.push && !stack_op.pop)
            sp_d = sp_q - 8'h01;
        else if (stack_op.pop && !stack_op.push)
            sp_d = sp_q + 8'h01;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            sp_q <= CRF_SP_RESET;
        else
            sp_q <= sp_d;
    end

    // ========================================
    // Program counter
    // A load wins over the advance so vectoring is never skipped.
    always_comb
    begin
        pc_d = {program_counter_high_q, program_counter_low_q};
        if (pc_ctl.load)
            pc_d = pc_ctl.value;
        else if (pc_ctl.advance)
            pc_d = pc_d + CRF_PC_STEP;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            program_counter_high_q <= CRF_PC_RESET[15:8];
            program_counter_low_q <= CRF_PC_RESET[7:0];
        end
        else
        begin
            program_counter_high_q <= pc_d[15:8];
            program_counter_low_q <= pc_d[7:0];
        end
    end

    // ========================================
    // First CPU mode register
    // A write of the unavailable mode code keeps the old mode field, since
    // the status outputs would have no defined meaning in it.
    // mode register write
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            cpu_mode_register_first_q <= CRF_MODE_REG_RESET;
        else if (mode_wr)
        begin
            cpu_mode_register_first_q <= mode_wdata;
            if (mode_wdata[CRF_MODE_LSB +: 2] == CRF_MODE_NONE)
                cpu_mode_register_first_q[CRF_MODE_LSB +: 2] <=
                    cpu_mode_register_first_q[CRF_MODE_LSB +: 2];
        end
    end

    assign mode_field = cpu_mode_register_first_q[CRF_MODE_LSB +: 2];

    // ========================================
    // Submodules
    crf_addr_calc u_addr
    (
        .clock(clock),
        .sys_rst(sys_rst),
        .idx_sel(idx_sel),
        .operand(operand),
        .x_val(x_q),
        .y_val(y_q),
        .sp_val(sp_q),
        .stack_page(cpu_mode_register_first_q[CRF_STACK_PAGE_BIT]),
        .eff_addr_q(eff_addr_q),
        .stack_addr_q(stack_addr_q)
    );

    crf_status_out u_status
    (
        .clock(clock),
        .sys_rst(sys_rst),
        .proc_mode(mode_field),
        .dma_busy(dma_busy),
        .fetch_cycle(fetch_cycle),
        .dma_activity_output_q(dma_activity_output_q),
        .opcode_fetch_marker_q(opcode_fetch_marker_q),
        .status_valid_q(status_valid_q)
    );

    // ========================================
    // Checks
    // Every antecedent but that of stack_low_a also tests the sampled reset, because the disable
    // condition sees the current value and would let the last reset edge in.
    sequence push_req_seq;
        !sys_rst && stack_op.push && !stack_op.pop && !(reg_wr.we && reg_wr.sel == CRF_SEL_SP);
    endsequence

    sequence pop_req_seq;
        !sys_rst && stack_op.pop && !stack_op.push && !(reg_wr.we && reg_wr.sel == CRF_SEL_SP);
    endsequence

    sequence sp_write_seq;
        !sys_rst && reg_wr.we && reg_wr.sel == CRF_SEL_SP;
    endsequence

    sequence mode_bad_wr_seq;
        !sys_rst && mode_wr && mode_wdata[CRF_MODE_LSB +: 2] == CRF_MODE_NONE;
    endsequence

    sequence mode_good_wr_seq;
        !sys_rst && mode_wr && mode_wdata[CRF_MODE_LSB +: 2] != CRF_MODE_NONE;
    endsequence

    acc_load_a: assert property (@(posedge clock) disable iff (sys_rst)
        !sys_rst && reg_wr.we && reg_wr.sel == CRF_SEL_A |=> acc_q == $past(reg_wr.data))
        else $error("Accumulator did not load");

    acc_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
        !sys_rst && !(reg_wr.we && reg_wr.sel == CRF_SEL_A) |=> $stable(acc_q))
        else $error("Accumulator changed without a write");

    x_load_a: assert property (@(posedge clock) disable iff (sys_rst)
        !sys_rst && reg_wr.we && reg_wr.sel == CRF_SEL_X |=> x_q == $past(reg_wr.data))
        else $error("First index register did not load");

    y_load_a: assert property (@(posedge clock) disable iff (sys_rst)
        !sys_rst && reg_wr.we && reg_wr.sel == CRF_SEL_Y |=> y_q == $past(reg_wr.data))
        else $error("Second index register did not load");

    idx_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
        !sys_rst && !reg_wr.we |=> $stable(x_q) && $stable(y_q))
        else $error("Index register changed without a write");

    sp_push_a: assert property (@(posedge clock) disable iff (sys_rst)
        push_req_seq |=> sp_q == $past(sp_q) - 8'h01)
        else $error("Push did not decrement pointer");

    sp_pop_a: assert property (@(posedge clock) disable iff (sys_rst)
        pop_req_seq |=> sp_q == $past(sp_q) + 8'h01)
        else $error("Pop did not increment pointer");

    sp_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
        !sys_rst && stack_op.push == stack_op.pop && !(reg_wr.we && reg_wr.sel == CRF_SEL_SP) |=> $stable(sp_q))
        else $error("Pointer moved without a request");

    sp_write_a: assert property (@(posedge clock) disable iff (sys_rst)
        sp_write_seq |=> sp_q == $past(reg_wr.data))
        else $error("Direct pointer write lost");

    stack_low_a: assert property (@(posedge clock) disable iff (sys_rst)
        1'b1 |=> stack_addr_q[7:0] == $past(sp_q))
        else $error("Stack low byte differs from pointer");

    // The stack address trails the pointer by one cycle, so a push shows two cycles after its request.
    // push reaches stack address
    push_addr_a: assert property (@(posedge clock) disable iff (sys_rst)
        push_req_seq |=> ##1 stack_addr_q[7:0] == $past(sp_q, 2) - 8'h01)
        else $error("Push not seen in stack address");

    pc_step_a: assert property (@(posedge clock) disable iff (sys_rst)
        !sys_rst && pc_ctl.advance && !pc_ctl.load |=>
        {program_counter_high_q, program_counter_low_q} ==
        $past({program_counter_high_q, program_counter_low_q}) + 16'h0001)
        else $error("Program counter did not advance");

    pc_load_a: assert property (@(posedge clock) disable iff (sys_rst)
        !sys_rst && pc_ctl.load |=> {program_counter_high_q, program_counter_low_q} == $past(pc_ctl.value))
        else $error("Program counter did not load");

    pc_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
        !sys_rst && !pc_ctl.load && !pc_ctl.advance |=> $stable({program_counter_high_q, program_counter_low_q}))
        else $error("Program counter moved while idle");

    mode_legal_a: assert property (@(posedge clock) disable iff (sys_rst)
        mode_field != CRF_MODE_NONE)
        else $error("Unavailable processor mode stored");

    mode_keep_a: assert property (@(posedge clock) disable iff (sys_rst)
        mode_bad_wr_seq |=> mode_field == $past(mode_field))
        else $error("Unavailable mode write changed the mode field");

    mode_take_a: assert property (@(posedge clock) disable iff (sys_rst)
        mode_good_wr_seq |=> cpu_mode_register_first_q == $past(mode_wdata))
        else $error("Mode register write lost");

    page_write_a: assert property (@(posedge clock) disable iff (sys_rst)
        !sys_rst && mode_wr |=>
        cpu_mode_register_first_q[CRF_STACK_PAGE_BIT] == $past(mode_wdata[CRF_STACK_PAGE_BIT]))
        else $error("Stack page bit not written");

endmodule
`default_nettype wire

// >>> verif/crf_bus_watch.sv
// Outside bus watcher: counts opcode fetch marks and DMA cycles, both only while the validity flag is high.
// Assumes the core's status outputs and validity flag share one clock.
`timescale 1ns/1ps
`default_nettype none
module crf_bus_watch
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic fetch_mark,
    input wire logic dma_mark,
    input wire logic valid,
    output int fetch_cnt,
    output int dma_cnt
);
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            fetch_cnt <= 0;
            dma_cnt <= 0;
        end
        else if (valid)
        begin
            fetch_cnt <= fetch_cnt + int'(fetch_mark);
            dma_cnt <= dma_cnt + int'(dma_mark);
        end
    end
endmodule
`default_nettype wire

// >>> verif/cpu_register_file_stack_addr_tb.sv
// Self-checking bench for the core register file with an integer model.
// Assumes every output is registered and updates one clock after its cause.
`timescale 1ns/1ps
`default_nettype none
module cpu_register_file_stack_addr_tb;
    import crf_pkg::*;
    logic clock, sys_rst, mode_wr, dma_busy, fetch_cycle;
    crf_wr_s reg_wr;
    crf_stk_s stack_op;
    crf_pc_s pc_ctl;
    crf_idx_e idx_sel;
    logic [15:0] operand, seed, eff_addr_q, stack_addr_q;
    logic [7:0] mode_wdata, acc_q, x_q, y_q, sp_q, program_counter_high_q, program_counter_low_q;
    logic [7:0] cpu_mode_register_first_q;
    logic dma_activity_output_q, opcode_fetch_marker_q, status_valid_q;
    int fetch_cnt, dma_cnt, error_cnt, checks;
    int a, x, y, sp, pc, md, ea, sa, dm, fm, sv, fcnt, dcnt;

    crf_core crf_core_inst (.clock, .sys_rst, .reg_wr, .stack_op, .pc_ctl, .idx_sel, .operand, .mode_wr,
        .mode_wdata, .dma_busy, .fetch_cycle, .acc_q, .x_q, .y_q, .sp_q, .program_counter_high_q,
        .program_counter_low_q, .cpu_mode_register_first_q, .eff_addr_q, .stack_addr_q,
        .dma_activity_output_q, .opcode_fetch_marker_q, .status_valid_q);

    crf_bus_watch crf_bus_watch_inst (.clock, .sys_rst, .fetch_mark(opcode_fetch_marker_q),
        .dma_mark(dma_activity_output_q), .valid(status_valid_q), .fetch_cnt, .dma_cnt);

    // ==========================================
    // Helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input string what, input logic [15:0] got, input int exp);
        checks++;
        if (got !== exp[15:0])
        begin
            error_cnt++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp[15:0]);
        end
    endtask

    task automatic test_done();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================
    // One clock: model the edge, drive new stimulus, compare.
    task automatic step(input logic rst);
        logic [15:0] r1, r2;
        @(posedge clock);
        if (sys_rst)
        begin
            {a, x, y, pc, md, ea, dm, fm, sv, fcnt, dcnt} = '0;
            sp = 255;
            sa = 255;
        end
        else
        begin
            ea = (operand + (idx_sel == CRF_IDX_X ? x : idx_sel == CRF_IDX_Y ? y : 0)) % 65536;
            sa = (md[CRF_STACK_PAGE_BIT] ? 256 : 0) + sp;
            sv = int'(md[1:0] == CRF_MODE_EXPAND || md[1:0] == CRF_MODE_MICRO);
            dm = int'(dma_busy);
            fm = int'(fetch_cycle);
            if (reg_wr.we)
                case (reg_wr.sel)
                    CRF_SEL_A: a = reg_wr.data;
                    CRF_SEL_X: x = reg_wr.data;
                    CRF_SEL_Y: y = reg_wr.data;
                    default: sp = reg_wr.data;
                endcase
            if (!(reg_wr.we && reg_wr.sel == CRF_SEL_SP) && stack_op.push != stack_op.pop)
                sp = (sp + (stack_op.pop ? 1 : 255)) % 256;
            pc = pc_ctl.load ? int'(pc_ctl.value) : pc_ctl.advance ? (pc + 1) % 65536 : pc;
            if (mode_wr)
                md = mode_wdata[1:0] == CRF_MODE_NONE ? {mode_wdata[7:2], md[1:0]} : mode_wdata;
        end
        fcnt += sv & fm;
        dcnt += sv & dm;
        r1 = lfsr(seed);
        r2 = lfsr(r1);
        seed = r2;
        sys_rst <= rst;
        reg_wr <= '{r1[0], crf_sel_e'(r1[2:1]), r2[7:0]};
        stack_op <= '{r1[3], r1[4]};
        pc_ctl <= '{r1[5], r1[6] & r1[7], {r2[7:0], r2[15:8]}};
        mode_wr <= r1[8] & r1[9];
        mode_wdata <= r2[15:8];
        dma_busy <= r1[10];
        fetch_cycle <= r1[11];
        idx_sel <= crf_idx_e'(r1[13:12] == 2'h3 ? 2'h0 : r1[13:12]);
        operand <= r2 ^ {r1[7:0], r1[15:8]};
        #1;
        chk("acc", acc_q, a);
        chk("x", x_q, x);
        chk("y", y_q, y);
        chk("sp", sp_q, sp);
        chk("pch", program_counter_high_q, pc / 256);
        chk("pcl", program_counter_low_q, pc % 256);
        chk("mode", cpu_mode_register_first_q, md);
        chk("eff", eff_addr_q, ea);
        chk("stack", stack_addr_q, sa);
        chk("dma", dma_activity_output_q, dm);
        chk("fetch", opcode_fetch_marker_q, fm);
        chk("valid", status_valid_q, sv);
    endtask

    // ==========================================
    // Clock, sequence and watchdog
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    initial
    begin
        {sys_rst, mode_wr, dma_busy, fetch_cycle} = 4'h8;
        reg_wr = '0;
        stack_op = '0;
        pc_ctl = '0;
        idx_sel = CRF_IDX_NONE;
        operand = 16'h0000;
        mode_wdata = 8'h00;
        seed = 16'h005a;
        error_cnt = 0;
        checks = 0;
        repeat (16) step(1'b1);
        repeat (1500) step(1'b0);
        repeat (3) step(1'b1);
        repeat (1500) step(1'b0);
        @(posedge clock);
        #1;
        chk("fetch count", fetch_cnt[15:0], fcnt);
        chk("dma count", dma_cnt[15:0], dcnt);
        test_done();
    end

    // The run needs about 3020 clocks; this allows roughly six and a half times that.
    initial
    begin
        #100000;
        error_cnt++;
        test_done();
    end
endmodule
`default_nettype wire
